// ### pkg/area_decode_pkg.sv
// Constants, types and register map of the virtual area decoder.
// Assumes a 32-bit byte-addressed Avalon-MM slave on one clock domain.
package area_decode_pkg;

   // Register byte offsets.
   localparam logic [7:0] XLATE_CTRL_OFS  = 8'h00;
   localparam logic [7:0] RAM_CTRL_OFS    = 8'h04;
   localparam logic [7:0] CACHE_CTRL_OFS  = 8'h08;
   localparam logic [7:0] SPACE_ID_OFS    = 8'h0c;
   localparam logic [7:0] ENTRY_SEL_OFS   = 8'h10;
   localparam logic [7:0] ENTRY_HI_OFS    = 8'h14;
   localparam logic [7:0] ENTRY_LO_OFS    = 8'h18;
   localparam logic [7:0] STATUS_OFS      = 8'h1c;

   // translation_control_reg fields.
   localparam int MAPPING_ON_BIT      = 0;
   localparam int EXT_FLAG_SEL_BIT    = 1;
   localparam int SQ_USER_LOCK_BIT    = 2;
   localparam int PHYS_EXT_MODE_BIT   = 3;
   // onchip_ram_control_reg field.
   localparam int RAM_USER_ACCESS_BIT = 0;
   // cache_control_reg fields.
   localparam int CACHE_ENABLE_BIT    = 0;
   localparam int CACHE_WT_SEL_BIT    = 1;
   localparam int DIRECT_CB_SEL_BIT   = 2;
   // Entry high word: [31:10] page number, [8] valid, [7:0] space id.
   localparam int ENTRY_VALID_BIT     = 8;
   // Entry low word: [31:10] frame, [6:4] size, [3] user ok, [2] cacheable, [1] wt.
   localparam int ENTRY_SIZE_LSB      = 4;
   localparam int ENTRY_USER_OK_BIT   = 3;
   localparam int ENTRY_CACHEABLE_BIT = 2;
   localparam int ENTRY_WT_BIT        = 1;

   // Reset values.
   localparam logic [31:0] XLATE_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] RAM_CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] CACHE_CTRL_RST = 32'h0000_0000;

   // Buffer sizes.
   localparam int UNIFIED_TRANSLATION_BUFFER_ENTRIES = 64;
   localparam int INSTR_TRANSLATION_BUFFER_ENTRIES = 4;

   // Control area windows: store queue E000_0000-E3FF_FFFF, on-chip memory E5xx_xxxx.
   localparam logic [5:0] SQ_TAG  = 6'h38;
   localparam logic [7:0] RAM_TAG = 8'he5;

   // Top three address bits per area.
   localparam logic [2:0] CACHED_DIRECT_TOP   = 3'h4;
   localparam logic [2:0] UNCACHED_DIRECT_TOP = 3'h5;
   localparam logic [2:0] PRIV_HIGH_TOP       = 3'h6;
   localparam logic [2:0] CONTROL_TOP         = 3'h7;

   typedef enum logic [5:0] {
      AREA_USER      = 6'b00_0001,
      AREA_PRIV_LOW  = 6'b00_0010,
      AREA_CACHED    = 6'b00_0100,
      AREA_UNCACHED  = 6'b00_1000,
      AREA_PRIV_HIGH = 6'b01_0000,
      AREA_CONTROL   = 6'b10_0000
   } area_e;

   typedef struct packed {
      logic        valid;
      logic        user;
      logic        instr;
      logic [31:0] vaddr;
   } access_req_s;

   typedef struct packed {
      area_e       area;
      logic        translate;
      logic        cacheable;
      logic        write_through;
      logic        addr_err;
      logic        miss;
      logic        prot_err;
      logic [31:0] paddr;
   } access_res_s;

   typedef struct packed {
      logic [21:0] vpn;
      logic [7:0]  space_id;
      logic [21:0] ppn;
      logic [2:0]  size;
      logic        user_ok;
      logic        cacheable;
      logic        wt;
   } tlb_entry_s;

endpackage

// ### verilog/virtual_area_decoder.sv
// Virtual area decoder with translation buffers and register file.
// Assumes the core holds its access request stable for the cycle it is decoded,
// and an Avalon-MM master on the same clock.
//
// Operation
// - Four instruction, sixty-four unified buffer entries.
// - Hardware copies unified entries into instruction buffer.
// - Control bit selects compatible or extended flags.
// - Support 29-bit and 32-bit physical address modes.
// - Separate access rights for privileged and user.
// - Privileged mode reaches whole virtual space.
// - User mode always reaches user area.
// - User store queue access needs lock clear.
// - User on-chip memory access needs enable set.
// - Other user accesses raise address error.
// - Mapping on translates user and privileged areas.
// - Extended operation adds more page sizes.
// - Eight-bit space id qualifies translation.
// - Translation off: clear top three bits.
// - Translation off: write policy from control.
// - Cache needs control enable and page cacheable.
// - Translation on: write policy from entry.
// - Cached direct area: untranslated, top bits cleared.
// - Cached direct write policy from copyback select.
// - Uncached direct area: no buffer, no cache.
// - Control area uncached, mostly untranslated; this code translates none of it.
// - Store queue at E000_0000 to E3FF_FFFF.
// - On-chip memory at E500_0000 to E5FF_FFFF.
// - Missing buffer entry raises translation miss.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
module virtual_area_decoder #(
   parameter int UNIFIED_TRANSLATION_BUFFER_N = area_decode_pkg::UNIFIED_TRANSLATION_BUFFER_ENTRIES,
   parameter int INSTR_TRANSLATION_BUFFER_N = area_decode_pkg::INSTR_TRANSLATION_BUFFER_ENTRIES
) (
   input  wire logic                         sys_clk_in,
   input  wire logic                         rst_in,
   input  wire area_decode_pkg::access_req_s req_in,
   output      area_decode_pkg::access_res_s res_out,
   input  wire logic [7:0]                   avs_address_in,
   input  wire logic                         avs_read_in,
   input  wire logic                         avs_write_in,
   input  wire logic [31:0]                  avs_writedata_in,
   input  wire logic [3:0]                   avs_byteenable_in,
   output      logic [31:0]                  avs_readdata_out,
   output      logic                         avs_waitrequest_out
);

   localparam int UW = $clog2(UNIFIED_TRANSLATION_BUFFER_N);
   localparam int IW = $clog2(INSTR_TRANSLATION_BUFFER_N);

   logic [31:0]                 xctl_q, xctl_d, rctl_q, rctl_d, cctl_q, cctl_d;
   logic [7:0]                  sid_q, sid_d;
   logic [UW-1:0]               sel_q, sel_d;
   logic [31:0]                 hi_q, hi_d;
   logic [15:0]                 miss_cnt_q, miss_cnt_d;
   logic [31:0]                 rdata_q, rdata_d;
   logic                        ack_q, ack_d;
   logic [IW-1:0]               iptr_q, iptr_d;
   logic [UNIFIED_TRANSLATION_BUFFER_N-1:0]           uval_q, uval_d;
   logic [INSTR_TRANSLATION_BUFFER_N-1:0]           ival_q, ival_d;
   area_decode_pkg::tlb_entry_s unified_translation_buffer_q [UNIFIED_TRANSLATION_BUFFER_N];
   area_decode_pkg::tlb_entry_s instr_translation_buffer_q [INSTR_TRANSLATION_BUFFER_N];
   logic                        acc, wr_en, lo_wr, fill;
   logic [UNIFIED_TRANSLATION_BUFFER_N-1:0]           uhit;
   logic [INSTR_TRANSLATION_BUFFER_N-1:0]           ihit;
   logic [UW-1:0]               uidx;
   logic [IW-1:0]               iidx;
   logic                        uany, iany, hit;
   area_decode_pkg::tlb_entry_s ent, new_ent;

   // Page size shift; compatible operation only knows four sizes.
   function automatic logic [4:0] page_shift(input logic [2:0] code, input logic ext);
      logic [2:0] c;
      c = code;
      if (!ext) begin
         case (code[1:0])
            2'h0:    c = 3'h0;
            2'h1:    c = 3'h1;
            2'h2:    c = 3'h3;
            default: c = 3'h5;
         endcase
      end
      case (c)
         3'h0:    page_shift = 5'd10;
         3'h1:    page_shift = 5'd12;
         3'h2:    page_shift = 5'd13;
         3'h3:    page_shift = 5'd16;
         3'h4:    page_shift = 5'd18;
         3'h5:    page_shift = 5'd20;
         3'h6:    page_shift = 5'd22;
         default: page_shift = 5'd26;
      endcase
   endfunction

   function automatic logic [31:0] page_mask(input logic [2:0] code, input logic ext);
      page_mask = (32'h0000_0001 << page_shift(code, ext)) - 32'h0000_0001;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      for (int b = 0; b < 4; b++) begin
         old[8*b +: 8] = be[b] ? nw[8*b +: 8] : old[8*b +: 8];
      end
      merge = old;
   endfunction

   // Buffer compare, qualified by the current process space id.
   for (genvar g = 0; g < UNIFIED_TRANSLATION_BUFFER_N; g++) begin : g_ucmp
      logic [31:0] m;
      assign m = page_mask(unified_translation_buffer_q[g].size, xctl_q[area_decode_pkg::EXT_FLAG_SEL_BIT]);
      assign uhit[g] = uval_q[g] && unified_translation_buffer_q[g].space_id == sid_q &&
                       ((req_in.vaddr[31:10] ^ unified_translation_buffer_q[g].vpn) & ~m[31:10]) == 22'h0;
   end
   for (genvar g = 0; g < INSTR_TRANSLATION_BUFFER_N; g++) begin : g_icmp
      logic [31:0] m;
      assign m = page_mask(instr_translation_buffer_q[g].size, xctl_q[area_decode_pkg::EXT_FLAG_SEL_BIT]);
      assign ihit[g] = ival_q[g] && instr_translation_buffer_q[g].space_id == sid_q &&
                       ((req_in.vaddr[31:10] ^ instr_translation_buffer_q[g].vpn) & ~m[31:10]) == 22'h0;
   end

   always_comb begin
      uidx = '0;
      iidx = '0;
      for (int i = UNIFIED_TRANSLATION_BUFFER_N - 1; i >= 0; i--) begin
         if (uhit[i]) begin
            uidx = UW'(i);
         end
      end
      for (int i = INSTR_TRANSLATION_BUFFER_N - 1; i >= 0; i--) begin
         if (ihit[i]) begin
            iidx = IW'(i);
         end
      end
      uany = |uhit;
      iany = |ihit;
   end

   // Instruction fetches try the small buffer first, then the unified one.
   assign hit = (req_in.instr && iany) || uany;
   assign ent = (req_in.instr && iany) ? instr_translation_buffer_q[iidx] : unified_translation_buffer_q[uidx];

   // Area decode and attributes, all combinational on the request.
   always_comb begin
      logic [2:0]  top;
      logic        sq, ram, xl_area, map_on;
      logic [31:0] m;
      top    = req_in.vaddr[31:29];
      sq     = req_in.vaddr[31:26] == area_decode_pkg::SQ_TAG;
      ram    = req_in.vaddr[31:24] == area_decode_pkg::RAM_TAG;
      map_on = xctl_q[area_decode_pkg::MAPPING_ON_BIT];
      xl_area = !top[2] || top == area_decode_pkg::PRIV_HIGH_TOP;
      m      = page_mask(ent.size, xctl_q[area_decode_pkg::EXT_FLAG_SEL_BIT]);
      res_out = '0;
      case (top)
         area_decode_pkg::CACHED_DIRECT_TOP:   res_out.area = area_decode_pkg::AREA_CACHED;
         area_decode_pkg::UNCACHED_DIRECT_TOP: res_out.area = area_decode_pkg::AREA_UNCACHED;
         area_decode_pkg::PRIV_HIGH_TOP:       res_out.area = area_decode_pkg::AREA_PRIV_HIGH;
         area_decode_pkg::CONTROL_TOP:         res_out.area = area_decode_pkg::AREA_CONTROL;
         default: begin
            res_out.area = req_in.user ? area_decode_pkg::AREA_USER
                                       : area_decode_pkg::AREA_PRIV_LOW;
         end
      endcase
      // Privileged mode never faults on area; user mode is fenced.
      res_out.addr_err = req_in.valid && req_in.user && top[2] &&
                         !(sq && !xctl_q[area_decode_pkg::SQ_USER_LOCK_BIT]) &&
                         !(ram && rctl_q[area_decode_pkg::RAM_USER_ACCESS_BIT]);
      res_out.translate = req_in.valid && xl_area && map_on && !res_out.addr_err;
      res_out.miss      = res_out.translate && !hit;
      // Pages carry their own user permission.
      res_out.prot_err  = res_out.translate && hit && req_in.user && !ent.user_ok;
      if (res_out.translate && hit) begin
         res_out.paddr = ({ent.ppn, 10'h000} & ~m) | (req_in.vaddr & m);
         if (!xctl_q[area_decode_pkg::PHYS_EXT_MODE_BIT]) begin
            res_out.paddr[31:29] = 3'h0;
         end
         // Cacheability needs both the global enable and the page bit.
         res_out.cacheable     = cctl_q[area_decode_pkg::CACHE_ENABLE_BIT] && ent.cacheable;
         res_out.write_through = ent.wt;
      end else if (top == area_decode_pkg::CONTROL_TOP) begin
         res_out.paddr = req_in.vaddr;
      end else begin
         res_out.paddr = {3'h0, req_in.vaddr[28:0]};
         if (xl_area) begin
            res_out.cacheable     = cctl_q[area_decode_pkg::CACHE_ENABLE_BIT];
            res_out.write_through = cctl_q[area_decode_pkg::CACHE_WT_SEL_BIT];
         end else if (top == area_decode_pkg::CACHED_DIRECT_TOP) begin
            res_out.cacheable     = cctl_q[area_decode_pkg::CACHE_ENABLE_BIT];
            res_out.write_through = !cctl_q[area_decode_pkg::DIRECT_CB_SEL_BIT];
         end
      end
      if (!req_in.valid || res_out.addr_err || res_out.miss) begin
         res_out.cacheable     = 1'b0;
         res_out.write_through = 1'b0;
      end
   end

   // Fill the instruction buffer on its miss when the unified buffer hits.
   assign fill = req_in.instr && res_out.translate && !iany && uany;

   // Register bus: one wait cycle, then the answer.
   assign acc   = (avs_read_in || avs_write_in) && !ack_q;
   // A write commits only at the edge where waitrequest is low, as the master expects.
   assign wr_en = avs_write_in && ack_q;
   assign lo_wr = wr_en && avs_address_in == area_decode_pkg::ENTRY_LO_OFS;
   assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_q;
   assign avs_readdata_out    = rdata_q;

   always_comb begin
      logic [31:0] lo;
      lo      = merge(32'h0, avs_writedata_in, avs_byteenable_in);
      xctl_d  = xctl_q;
      rctl_d  = rctl_q;
      cctl_d  = cctl_q;
      sid_d   = sid_q;
      sel_d   = sel_q;
      hi_d    = hi_q;
      rdata_d = rdata_q;
      ack_d   = acc;
      if (wr_en) begin
         case (avs_address_in)
            area_decode_pkg::XLATE_CTRL_OFS: begin
               xctl_d = merge(xctl_q, avs_writedata_in, avs_byteenable_in) & 32'h0000_000f;
            end
            area_decode_pkg::RAM_CTRL_OFS: begin
               rctl_d = merge(rctl_q, avs_writedata_in, avs_byteenable_in) & 32'h0000_0001;
            end
            area_decode_pkg::CACHE_CTRL_OFS: begin
               cctl_d = merge(cctl_q, avs_writedata_in, avs_byteenable_in) & 32'h0000_0007;
            end
            area_decode_pkg::SPACE_ID_OFS: begin
               sid_d = avs_byteenable_in[0] ? avs_writedata_in[7:0] : sid_q;
            end
            area_decode_pkg::ENTRY_SEL_OFS: begin
               sel_d = lo[UW-1:0];
            end
            area_decode_pkg::ENTRY_HI_OFS: begin
               hi_d = merge(hi_q, avs_writedata_in, avs_byteenable_in) & 32'hffff_fdff;
            end
            default: begin
            end
         endcase
      end
      if (acc && avs_read_in) begin
         case (avs_address_in)
            area_decode_pkg::XLATE_CTRL_OFS: rdata_d = xctl_q;
            area_decode_pkg::RAM_CTRL_OFS:   rdata_d = rctl_q;
            area_decode_pkg::CACHE_CTRL_OFS: rdata_d = cctl_q;
            area_decode_pkg::SPACE_ID_OFS:   rdata_d = {24'h0, sid_q};
            area_decode_pkg::ENTRY_SEL_OFS:  rdata_d = 32'(sel_q);
            area_decode_pkg::ENTRY_HI_OFS:   rdata_d = hi_q;
            area_decode_pkg::STATUS_OFS:     rdata_d = {14'h0, 2'(iptr_q), miss_cnt_q};
            default:                         rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // Buffer bookkeeping: a new unified entry flushes the instruction copies.
   always_comb begin
      new_ent           = '0;
      new_ent.vpn       = hi_q[31:10];
      new_ent.space_id  = hi_q[7:0];
      new_ent.ppn       = avs_writedata_in[31:10];
      new_ent.size      = avs_writedata_in[area_decode_pkg::ENTRY_SIZE_LSB +: 3];
      new_ent.user_ok   = avs_writedata_in[area_decode_pkg::ENTRY_USER_OK_BIT];
      new_ent.cacheable = avs_writedata_in[area_decode_pkg::ENTRY_CACHEABLE_BIT];
      new_ent.wt        = avs_writedata_in[area_decode_pkg::ENTRY_WT_BIT];
      uval_d     = uval_q;
      ival_d     = ival_q;
      iptr_d     = iptr_q;
      miss_cnt_d = miss_cnt_q + 16'(res_out.miss);
      if (lo_wr) begin
         uval_d[sel_q] = hi_q[area_decode_pkg::ENTRY_VALID_BIT];
         ival_d        = '0;
      end else if (fill) begin
         ival_d[iptr_q] = 1'b1;
         iptr_d         = iptr_q + IW'(1);
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         xctl_q     <= area_decode_pkg::XLATE_CTRL_RST;
         rctl_q     <= area_decode_pkg::RAM_CTRL_RST;
         cctl_q     <= area_decode_pkg::CACHE_CTRL_RST;
         sid_q      <= '0;
         sel_q      <= '0;
         hi_q       <= '0;
         rdata_q    <= '0;
         ack_q      <= 1'b0;
         uval_q     <= '0;
         ival_q     <= '0;
         iptr_q     <= '0;
         miss_cnt_q <= '0;
      end else begin
         xctl_q     <= xctl_d;
         rctl_q     <= rctl_d;
         cctl_q     <= cctl_d;
         sid_q      <= sid_d;
         sel_q      <= sel_d;
         hi_q       <= hi_d;
         rdata_q    <= rdata_d;
         ack_q      <= ack_d;
         uval_q     <= uval_d;
         ival_q     <= ival_d;
         iptr_q     <= iptr_d;
         miss_cnt_q <= miss_cnt_d;
      end
   end

   // Entry payloads need no reset because the valid bits guard them.
   always_ff @(posedge sys_clk_in) begin
      if (lo_wr) begin
         unified_translation_buffer_q[sel_q] <= new_ent;
      end
      if (fill && !lo_wr) begin
         instr_translation_buffer_q[iptr_q] <= unified_translation_buffer_q[uidx];
      end
   end

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);

   a_priv_no_err : assert property (req_in.valid && !req_in.user |-> !res_out.addr_err)
      else $error("privileged access flagged as address error");
   a_user_area_ok : assert property (req_in.valid && req_in.user && !req_in.vaddr[31]
      |-> !res_out.addr_err)
      else $error("user area access faulted");
   a_sq_lock : assert property (req_in.valid && req_in.user && req_in.vaddr[31:26] == 6'h38
      |-> res_out.addr_err == xctl_q[2])
      else $error("store queue user gate wrong");
   a_ram_gate : assert property (req_in.valid && req_in.user && req_in.vaddr[31:24] == 8'he5
      |-> res_out.addr_err == !rctl_q[0])
      else $error("on-chip memory user gate wrong");
   a_user_fence : assert property (req_in.valid && req_in.user && req_in.vaddr[31:28] == 4'hf
      |-> res_out.addr_err)
      else $error("user access to fenced area allowed");
   a_direct_addr : assert property (req_in.valid && req_in.vaddr[31:30] == 2'b10
      |-> !res_out.translate && res_out.paddr == {3'h0, req_in.vaddr[28:0]})
      else $error("direct area address wrong");
   a_uncached : assert property (req_in.vaddr[31:29] == 3'h5 || req_in.vaddr[31:29] == 3'h7
      |-> !res_out.cacheable)
      else $error("uncached area marked cacheable");
   a_xlate_off : assert property (req_in.valid && !xctl_q[0] && !req_in.vaddr[31]
      |-> !res_out.translate && res_out.paddr[31:29] == 3'h0)
      else $error("untranslated address wrong");
   a_miss_flag : assert property (res_out.miss |-> res_out.translate && !uany)
      else $error("miss flagged with a hit");
   a_instr_translation_buffer_fill : assert property (fill && !lo_wr |=> ival_q[$past(iptr_q)] &&
      iptr_q == $past(iptr_q) + IW'(1))
      else $error("instruction buffer not filled");
   a_bus_wait : assert property (avs_write_in && avs_waitrequest_out
      |=> !avs_waitrequest_out)
      else $error("bus answer later than one cycle");

   c_fill     : cover property (fill);
   c_miss     : cover property (res_out.miss);
   c_user_err : cover property (res_out.addr_err);
   c_ram_ok   : cover property (req_in.user && req_in.vaddr[31:24] == 8'he5 && !res_out.addr_err);

endmodule

// ### verification/core_access_model.sv
// Processor core model that issues one instruction or data access per cycle.
// Assumes the decoder answers combinationally within the cycle of the access.
`timescale 1ns/1ns
module core_access_model (
   input  wire logic                         sys_clk_in,
   output      area_decode_pkg::access_req_s req_out
);
   logic [31:0] last_addr_q;

   initial begin
      req_out = '0;
      last_addr_q = 32'h0000_0000;
   end

   // The access stays on the port from this edge until the next present or go_idle call.
   task automatic present(input logic user, input logic instr, input logic [31:0] addr);
      @(posedge sys_clk_in);
      req_out <= '{valid: 1'b1, user: user, instr: instr, vaddr: addr};
      last_addr_q <= addr;
      @(negedge sys_clk_in);
   endtask

   // An idle bus shows an inverted address, so a stale value is never mistaken for a live one.
   task automatic go_idle();
      @(posedge sys_clk_in);
      req_out <= '{valid: 1'b0, user: 1'b0, instr: 1'b0, vaddr: ~last_addr_q};
   endtask
endmodule

// ### verification/virtual_area_decoder_tb_top.sv
// Self-checking bench for the virtual area decoder: registers, area decode and translation.
// Assumes core_access_model drives the access port and this bench drives the register bus.
`timescale 1ns/1ns
module virtual_area_decoder_tb_top;
   logic                         sys_clk_in;
   logic                         rst_in;
   area_decode_pkg::access_req_s req;
   area_decode_pkg::access_res_s res;
   logic [7:0]                   avs_address_in;
   logic                         avs_read_in;
   logic                         avs_write_in;
   logic [31:0]                  avs_writedata_in;
   logic [3:0]                   avs_byteenable_in;
   logic [31:0]                  avs_readdata_out;
   logic                         avs_waitrequest_out;
   logic [31:0]                  rd;
   logic [31:0]                  base;
   int                           num_errors = 0;
   int                           cmp_count = 0;
   int                           cycles = 0;

   virtual_area_decoder virtual_area_decoder_inst (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in), .req_in(req), .res_out(res),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out));
   core_access_model core_access_model_inst (.sys_clk_in(sys_clk_in), .req_out(req));

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // The request is held until the rising edge at which waitrequest is sampled low.
   task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
      @(posedge sys_clk_in);
      avs_address_in <= addr;
      avs_writedata_in <= wdata;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      do
         @(posedge sys_clk_in);
      while (avs_waitrequest_out !== 1'b0);
      rd = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask

   task automatic acc(input logic user, input logic [31:0] addr);
      core_access_model_inst.present(user, 1'b0, addr);
   endtask

   task automatic t_regs();
      bus(1'b0, area_decode_pkg::XLATE_CTRL_OFS, 32'h0000_0000);
      chk_val("xlate ctrl", area_decode_pkg::XLATE_CTRL_RST, rd);
      bus(1'b0, area_decode_pkg::RAM_CTRL_OFS, 32'h0000_0000);
      chk_val("ram ctrl", area_decode_pkg::RAM_CTRL_RST, rd);
      bus(1'b0, area_decode_pkg::CACHE_CTRL_OFS, 32'h0000_0000);
      chk_val("cache ctrl", area_decode_pkg::CACHE_CTRL_RST, rd);
      bus(1'b1, 8'h40, 32'hffff_ffff);
      bus(1'b0, 8'h40, 32'h0000_0000);
      chk_val("unmapped", 32'h0000_0000, rd);
      bus(1'b1, area_decode_pkg::SPACE_ID_OFS, 32'h0000_00a5);
      bus(1'b0, area_decode_pkg::SPACE_ID_OFS, 32'h0000_0000);
      chk_val("space id", 32'h0000_00a5, rd);
   endtask

   task automatic t_priv();
      logic [31:0] adr [5] = '{32'h1234_5678, 32'h8765_4321, 32'hb000_0010, 32'hd000_0020,
                               32'hf000_0030};
      area_decode_pkg::area_e ar [5] = '{area_decode_pkg::AREA_PRIV_LOW,
         area_decode_pkg::AREA_CACHED, area_decode_pkg::AREA_UNCACHED,
         area_decode_pkg::AREA_PRIV_HIGH, area_decode_pkg::AREA_CONTROL};
      for (int i = 0; i < 5; i++) begin
         acc(1'b0, adr[i]);
         chk_val("area", ar[i], res.area);
         chk_val("addr_err", 1'b0, res.addr_err);
         chk_val("paddr", (i == 4) ? adr[i] : {3'h0, adr[i][28:0]}, res.paddr);
         chk_val("cacheable", 1'b0, res.cacheable);
      end
   endtask

   task automatic t_user();
      logic [31:0] adr [10] = '{32'h0000_1000, 32'h8000_0000, 32'he000_0000, 32'he3ff_fffc,
         32'he400_0000, 32'he500_0000, 32'he3ff_fffc, 32'he500_0000, 32'he5ff_fffc,
         32'he600_0000};
      logic [9:0] err = 10'h272;
      for (int i = 0; i < 10; i++) begin
         if (i == 6) begin
            bus(1'b1, area_decode_pkg::XLATE_CTRL_OFS, 32'h0000_0004);
            bus(1'b1, area_decode_pkg::RAM_CTRL_OFS, 32'h0000_0001);
         end
         acc(1'b1, adr[i]);
         chk_val("user addr_err", err[i], res.addr_err);
      end
      acc(1'b1, 32'h7fff_fff0);
      chk_val("user area", area_decode_pkg::AREA_USER, res.area);
      bus(1'b1, area_decode_pkg::XLATE_CTRL_OFS, 32'h0000_0000);
      bus(1'b1, area_decode_pkg::RAM_CTRL_OFS, 32'h0000_0000);
   endtask

   task automatic t_cache();
      bus(1'b1, area_decode_pkg::CACHE_CTRL_OFS, 32'h0000_0003);
      acc(1'b0, 32'h0000_2000);
      chk_val("low cacheable", 1'b1, res.cacheable);
      chk_val("low wt", 1'b1, res.write_through);
      acc(1'b0, 32'h8000_2000);
      chk_val("direct cacheable", 1'b1, res.cacheable);
      chk_val("direct wt", 1'b1, res.write_through);
      acc(1'b0, 32'ha000_2000);
      chk_val("uncached", 1'b0, res.cacheable);
      acc(1'b0, 32'hfc00_0000);
      chk_val("control", 1'b0, res.cacheable);
      bus(1'b1, area_decode_pkg::CACHE_CTRL_OFS, 32'h0000_0005);
      acc(1'b0, 32'h0000_2000);
      chk_val("low wt off", 1'b0, res.write_through);
      acc(1'b0, 32'h8000_2000);
      chk_val("copy-back", 1'b0, res.write_through);
   endtask

   task automatic t_translate();
      logic [31:0] cfg [12] = '{32'h1, 32'h12, 32'h0, 32'h0040_0112, 32'h0010_001e, 32'h1,
         32'h0080_0112, 32'h0020_0010, 32'h2, 32'h0800_0112, 32'hf400_0078, 32'h1};
      logic [7:0] ofs [4] = '{8'h10, 8'h14, 8'h18, 8'h10};
      bus(1'b1, area_decode_pkg::CACHE_CTRL_OFS, cfg[0]);
      bus(1'b1, area_decode_pkg::SPACE_ID_OFS, cfg[1]);
      for (int i = 2; i < 11; i++) begin
         bus(1'b1, ofs[(i - 2) % 3], cfg[i]);
      end
      bus(1'b1, area_decode_pkg::XLATE_CTRL_OFS, cfg[11]);
      acc(1'b0, 32'h0040_0123);
      chk_val("translate", 1'b1, res.translate);
      chk_val("mapped paddr", 32'h0010_0123, res.paddr);
      chk_val("page cacheable", 1'b1, res.cacheable);
      chk_val("page wt", 1'b1, res.write_through);
      core_access_model_inst.present(1'b1, 1'b1, 32'h0040_0124);
      chk_val("fetch paddr", 32'h0010_0124, res.paddr);
      chk_val("user ok", 1'b0, res.prot_err);
      acc(1'b1, 32'h0080_0010);
      chk_val("user denied", 1'b1, res.prot_err);
      acc(1'b0, 32'h0080_0010);
      chk_val("page uncached", 1'b0, res.cacheable);
      acc(1'b0, 32'h0bff_fff0);
      chk_val("compat size", 1'b1, res.miss);
      bus(1'b1, area_decode_pkg::XLATE_CTRL_OFS, 32'h0000_0003);
      acc(1'b0, 32'h0bff_fff0);
      chk_val("ext paddr", 32'h17ff_fff0, res.paddr);
      bus(1'b1, area_decode_pkg::XLATE_CTRL_OFS, 32'h0000_000b);
      acc(1'b0, 32'h0bff_fff0);
      chk_val("wide paddr", 32'hf7ff_fff0, res.paddr);
      bus(1'b1, area_decode_pkg::SPACE_ID_OFS, 32'h0000_0013);
      acc(1'b0, 32'h0040_0123);
      chk_val("other space", 1'b1, res.miss);
      core_access_model_inst.go_idle();
      bus(1'b0, area_decode_pkg::STATUS_OFS, 32'h0000_0000);
      base = rd;
      acc(1'b0, 32'hc040_0123);
      chk_val("high miss", 1'b1, res.miss);
      core_access_model_inst.go_idle();
      bus(1'b0, area_decode_pkg::STATUS_OFS, 32'h0000_0000);
      chk_val("miss count", {16'h0, base[15:0] + 16'h0001}, {16'h0, rd[15:0]});
   endtask

   initial begin
      sys_clk_in = 1'b0;
      forever #4 sys_clk_in = ~sys_clk_in;
   end

   // Whole run needs under two hundred cycles; the ceiling of 20000 leaves wide margin.
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         close_out();
      end
   end

   initial begin
      rst_in = 1'b1;
      avs_address_in = 8'h00;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_writedata_in = 32'h0000_0000;
      avs_byteenable_in = 4'hf;
      repeat (5) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      t_regs();
      t_priv();
      t_user();
      t_cache();
      t_translate();
      close_out();
   end
endmodule
